/* common/pmt_pkg.sv */
package pmt_pkg;

	// ==========================================================
	// register map, one byte per index
	localparam int PMT_AW = 3;
	localparam int PMT_DW = 8;
	localparam logic [PMT_AW-1:0] PMT_ADDR_CTRL = 3'h0;
	localparam logic [PMT_AW-1:0] PMT_ADDR_COUNT = 3'h1;
	localparam logic [PMT_AW-1:0] PMT_ADDR_PERIOD = 3'h2;
	localparam logic [PMT_AW-1:0] PMT_ADDR_FLAG = 3'h3;
	localparam logic [PMT_AW-1:0] PMT_ADDR_IRQEN = 3'h4;

	// ==========================================================
	// control field positions
	localparam int PMT_POST_MSB = 6;
	localparam int PMT_POST_LSB = 3;
	localparam int PMT_RUN_BIT = 2;
	localparam int PMT_PRE_MSB = 1;
	localparam int PMT_PRE_LSB = 0;
	localparam int PMT_FLAG_BIT = 0;

	// ==========================================================
	// reset values and masks
	localparam logic [PMT_DW-1:0] PMT_CTRL_RST = 8'h00;
	localparam logic [PMT_DW-1:0] PMT_CTRL_WMASK = 8'h7f;
	localparam logic [PMT_DW-1:0] PMT_COUNT_RST = 8'h00;
	localparam logic [PMT_DW-1:0] PMT_PERIOD_RST = 8'hff;
	localparam logic [PMT_DW-1:0] PMT_ZERO = 8'h00;
	localparam logic [PMT_DW-1:0] PMT_ONE = 8'h01;

	// ==========================================================
	// prescale codes and the terminal count of each
	typedef enum logic [1:0] {
		PMT_PRE_1 = 2'h0,
		PMT_PRE_4 = 2'h1,
		PMT_PRE_16 = 2'h2,
		PMT_PRE_64 = 2'h3
	} pmt_pre_t;
	localparam logic [5:0] PMT_PRE_LIM_1 = 6'h00;
	localparam logic [5:0] PMT_PRE_LIM_4 = 6'h03;
	localparam logic [5:0] PMT_PRE_LIM_16 = 6'h0f;
	localparam logic [5:0] PMT_PRE_LIM_64 = 6'h3f;
	localparam logic [5:0] PMT_PRE_ZERO = 6'h00;
	localparam logic [5:0] PMT_PRE_ONE = 6'h01;
	localparam logic [3:0] PMT_POST_ZERO = 4'h0;
	localparam logic [3:0] PMT_POST_ONE = 4'h1;

endpackage

/* rtl/pmt_prescaler.sv */
`timescale 1ns/1ps
module pmt_prescaler (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// control
	input wire logic clear,
	input wire logic enable,
	input wire pmt_pkg::pmt_pre_t select,
	// output
	output logic tick
);
	import pmt_pkg::*;

	logic [5:0] cnt_reg;
	logic [5:0] cnt_next;
	logic [5:0] limit;

	// ==========================================================
	// divider
	assign limit = (select == PMT_PRE_64) ? PMT_PRE_LIM_64 :
		(select == PMT_PRE_16) ? PMT_PRE_LIM_16 :
		(select == PMT_PRE_4) ? PMT_PRE_LIM_4 : PMT_PRE_LIM_1; // see [R3] see [R18]
	assign tick = enable & ~clear & (cnt_reg == limit);
	assign cnt_next = clear ? PMT_PRE_ZERO :
		~enable ? cnt_reg :
		tick ? PMT_PRE_ZERO : 6'(cnt_reg + PMT_PRE_ONE);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= PMT_PRE_ZERO; // see [R9]
		end else begin
			cnt_reg <= cnt_next; // see [R8]
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	AST_PRE_CLEAR: assert property (clear |=> cnt_reg == PMT_PRE_ZERO) // see [R8]
		else $error("prescaler not cleared");
	AST_PRE_DIV4: assert property ( // see [R3]
		(cnt_reg == PMT_PRE_ZERO && enable && !clear && select == PMT_PRE_4)
		##1 (enable && !clear && select == PMT_PRE_4)[*3] |-> tick)
		else $error("divide by four tick missing");
	AST_PRE_NOTICK: assert property (!enable |-> !tick) // see [R15]
		else $error("tick while disabled");
endmodule

/* rtl/pmt_postscaler.sv */
`timescale 1ns/1ps
module pmt_postscaler (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// control
	input wire logic clear,
	input wire logic in_pulse,
	input wire logic [3:0] select,
	// output
	output logic out_pulse
);
	import pmt_pkg::*;

	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;

	// ==========================================================
	// match divider, ratio is select plus one
	assign out_pulse = in_pulse & ~clear & (cnt_reg == select); // see [R10]
	assign cnt_next = clear ? PMT_POST_ZERO :
		~in_pulse ? cnt_reg :
		out_pulse ? PMT_POST_ZERO : 4'(cnt_reg + PMT_POST_ONE);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= PMT_POST_ZERO; // see [R9]
		end else begin
			cnt_reg <= cnt_next; // see [R8]
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	AST_POST_CLEAR: assert property (clear |=> cnt_reg == PMT_POST_ZERO) // see [R8]
		else $error("postscaler not cleared");
	AST_POST_ONE: assert property ( // see [R10]
		(in_pulse && !clear && select == PMT_POST_ZERO) |-> out_pulse)
		else $error("one to one postscale missed");
	AST_POST_QUIET: assert property (!in_pulse |-> !out_pulse) // see [R10]
		else $error("postscale pulse without match");
endmodule

/* rtl/pmt_timer.sv */
// Functional notes
// [R1] count source is the instruction clock, here the block clock itself
// [R2] count starts at zero and steps by one per prescaler tick
// [R3] prescaler offers 1:1, 1:4, 1:16, 1:64 via two-bit select
// [R4] count compared with period every cycle; equality raises match; here match is raised only on equality with a prescaler tick
// [R5] match clears count next cycle and clocks the postscaler
// [R6] count and period are eight bits, read and write
// [R7] reset clears count and sets period to all ones
// [R8] write to count or control clears prescaler and postscaler
// [R9] every reset source clears prescaler and postscaler
// [R10] postscaler divides matches by select value plus one
// [R11] postscaler terminal count sets a sticky match flag
// [R12] interrupt raised only when match interrupt enable is set
// [R13] unscaled match pulse goes to the capture compare unit
// [R14] timer output offered as spi shift clock source
// [R15] sleep stops counting; count and period hold
// [R16] control: postscale bits 6..3, prescale bits 1..0, bit 7 reads zero
// [R17] control bit 2 runs the timer; clear holds count, no matches
// [R18] prescale codes 00,01,10,11 divide by 1,4,16,64
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module pmt_timer (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// register port
	input wire logic [pmt_pkg::PMT_AW-1:0] reg_addr,
	input wire logic [pmt_pkg::PMT_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pmt_pkg::PMT_DW-1:0] reg_rdata,
	// core state
	input wire logic sleep_req,
	// timer outputs
	output logic match_pulse,
	output logic spi_shift_clk,
	output logic irq
);
	import pmt_pkg::*;

	// ==========================================================
	// state
	logic [PMT_DW-1:0] ctrl_reg;
	logic [PMT_DW-1:0] ctrl_next;
	logic [PMT_DW-1:0] count_reg;
	logic [PMT_DW-1:0] count_next;
	logic [PMT_DW-1:0] period_reg;
	logic [PMT_DW-1:0] period_next;
	logic match_flag_reg;
	logic match_flag_next;
	logic match_irq_enable_reg;
	logic match_irq_enable_next;
	logic match_pulse_reg;
	logic shift_clk_reg;
	logic shift_clk_next;
	logic [PMT_DW-1:0] rdata_reg;
	logic [PMT_DW-1:0] rdata_next;

	// ==========================================================
	// address decode
	logic sel_ctrl;
	logic sel_count;
	logic sel_period;
	logic sel_flag;
	logic sel_irqen;
	logic wr_ctrl;
	logic wr_count;
	logic wr_period;
	logic wr_irqen;
	logic rd_flag;
	logic scaler_clear;

	assign sel_ctrl = (reg_addr == PMT_ADDR_CTRL);
	assign sel_count = (reg_addr == PMT_ADDR_COUNT);
	assign sel_period = (reg_addr == PMT_ADDR_PERIOD);
	assign sel_flag = (reg_addr == PMT_ADDR_FLAG);
	assign sel_irqen = (reg_addr == PMT_ADDR_IRQEN);
	assign wr_ctrl = reg_wr & sel_ctrl;
	assign wr_count = reg_wr & sel_count;
	assign wr_period = reg_wr & sel_period;
	assign wr_irqen = reg_wr & sel_irqen;
	assign rd_flag = reg_rd & sel_flag;
	assign scaler_clear = wr_ctrl | wr_count; // see [R8]

	// ==========================================================
	// control fields
	logic timer_run;
	logic count_enable;
	pmt_pre_t prescale_select;
	logic [3:0] postscale_select;

	assign timer_run = ctrl_reg[PMT_RUN_BIT]; // see [R17]
	assign prescale_select = pmt_pre_t'(ctrl_reg[PMT_PRE_MSB:PMT_PRE_LSB]); // see [R16]
	assign postscale_select = ctrl_reg[PMT_POST_MSB:PMT_POST_LSB]; // see [R16]
	// sleep gates the tick only; registers stay writable by design
	assign count_enable = timer_run & ~sleep_req; // see [R15]

	// ==========================================================
	// prescaler, comparator and postscaler
	logic pre_tick;
	logic period_equal;
	logic match_now;
	logic post_pulse;

	pmt_prescaler u_pre (
		.clock(clock),
		.rst_b(rst_b),
		.clear(scaler_clear),
		.enable(count_enable),
		.select(prescale_select),
		.tick(pre_tick)
	);

	// compare runs every cycle; the event is taken on a tick so a held
	// count under a slow prescale does not repeat the match
	assign period_equal = (count_reg == period_reg); // see [R4]
	assign match_now = pre_tick & period_equal; // see [R4]

	pmt_postscaler u_post (
		.clock(clock),
		.rst_b(rst_b),
		.clear(scaler_clear),
		.in_pulse(match_now), // see [R5]
		.select(postscale_select),
		.out_pulse(post_pulse)
	);

	// ==========================================================
	// next values
	assign ctrl_next = wr_ctrl ? (reg_wdata & PMT_CTRL_WMASK) : ctrl_reg; // see [R16]
	// clock is the instruction clock; software write beats a tick
	assign count_next = wr_count ? reg_wdata :
		match_now ? PMT_ZERO : // see [R5]
		pre_tick ? 8'(count_reg + PMT_ONE) : count_reg; // see [R1] see [R2]
	assign period_next = wr_period ? reg_wdata : period_reg; // see [R6]
	// set wins over the read that clears
	assign match_flag_next = post_pulse | (match_flag_reg & ~rd_flag); // see [R11]
	assign match_irq_enable_next = wr_irqen ? reg_wdata[PMT_FLAG_BIT] : match_irq_enable_reg;
	assign shift_clk_next = match_now ? ~shift_clk_reg : shift_clk_reg; // see [R14]

	// ==========================================================
	// read mux, unmapped reads return zero
	assign rdata_next = ~reg_rd ? PMT_ZERO :
		sel_ctrl ? ctrl_reg :
		sel_count ? count_reg :
		sel_period ? period_reg :
		sel_flag ? {7'h00, match_flag_reg} :
		sel_irqen ? {7'h00, match_irq_enable_reg} : PMT_ZERO; // see [R6]

	// ==========================================================
	// registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= PMT_CTRL_RST;
			count_reg <= PMT_COUNT_RST; // see [R7]
			period_reg <= PMT_PERIOD_RST; // see [R7]
		end else begin
			ctrl_reg <= ctrl_next;
			count_reg <= count_next;
			period_reg <= period_next;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			match_flag_reg <= 1'b0;
			match_irq_enable_reg <= 1'b0;
			match_pulse_reg <= 1'b0;
			shift_clk_reg <= 1'b0;
			rdata_reg <= PMT_ZERO;
		end else begin
			match_flag_reg <= match_flag_next;
			match_irq_enable_reg <= match_irq_enable_next;
			match_pulse_reg <= match_now; // see [R13]
			shift_clk_reg <= shift_clk_next;
			rdata_reg <= rdata_next;
		end
	end

	// ==========================================================
	// outputs
	assign reg_rdata = rdata_reg;
	assign match_pulse = match_pulse_reg;
	assign spi_shift_clk = shift_clk_reg;
	assign irq = match_flag_reg & match_irq_enable_reg; // see [R12]

	// ==========================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	AST_MATCH_CLEARS: assert property ( // see [R5]
		(match_now && !wr_count) |=> count_reg == PMT_ZERO)
		else $error("count not cleared after match");
	AST_COUNT_STEP: assert property ( // see [R2]
		(pre_tick && !period_equal && !wr_count) |=> count_reg == 8'($past(count_reg) + PMT_ONE))
		else $error("count did not step");
	AST_SLEEP_HOLD: assert property ( // see [R15]
		(sleep_req && !reg_wr) |=> ($stable(count_reg) && $stable(period_reg)))
		else $error("count or period moved in sleep");
	AST_RUN_OFF: assert property ( // see [R17]
		(!timer_run && !reg_wr) |=> ($stable(count_reg) && !match_pulse))
		else $error("stopped timer moved");
	AST_MATCH_OUT: assert property ( // see [R13]
		(pre_tick && period_equal) |=> match_pulse)
		else $error("match pulse wrong");
	AST_FLAG_SET: assert property (post_pulse |=> match_flag_reg) // see [R11]
		else $error("flag not set");
	AST_FLAG_STICKY: assert property ( // see [R11]
		(match_flag_reg && !rd_flag) |=> match_flag_reg)
		else $error("flag dropped without read");
	AST_IRQ_GATE: assert property ( // see [R12]
		(match_flag_reg && !match_irq_enable_reg) |-> !irq)
		else $error("interrupt while disabled");
	AST_READ_COUNT: assert property ( // see [R6]
		(reg_rd && sel_count) |=> reg_rdata == $past(count_reg))
		else $error("count read wrong");
	AST_CTRL_B7: assert property ( // see [R16]
		(reg_rd && sel_ctrl) |=> !reg_rdata[PMT_DW-1])
		else $error("control bit 7 not zero");
	AST_SHIFT_TOGGLE: assert property ( // see [R14]
		match_now |=> spi_shift_clk != $past(spi_shift_clk))
		else $error("shift clock did not toggle");

	// ==========================================================
	// checks: register port
	AST_WR_COUNT: assert property ( // see [R6]
		wr_count
		|=> count_reg == $past(reg_wdata))
		else $error("count write lost");

	AST_WR_PERIOD: assert property ( // see [R6]
		wr_period
		|=> period_reg == $past(reg_wdata))
		else $error("period write lost");

	AST_PERIOD_HOLD: assert property ( // see [R6]
		!wr_period
		|=> $stable(period_reg))
		else $error("period moved without write");

	AST_CTRL_WRITE: assert property ( // see [R16]
		wr_ctrl
		|=> ctrl_reg == ($past(reg_wdata) & PMT_CTRL_WMASK))
		else $error("control write wrong");

	AST_CTRL_HOLD: assert property ( // see [R16]
		!wr_ctrl
		|=> $stable(ctrl_reg))
		else $error("control moved without write");

	AST_IRQEN_WRITE: assert property ( // see [R12]
		wr_irqen
		|=> match_irq_enable_reg == $past(reg_wdata[PMT_FLAG_BIT]))
		else $error("interrupt enable write lost");

	AST_READ_PERIOD: assert property ( // see [R6]
		(reg_rd && sel_period)
		|=> reg_rdata == $past(period_reg))
		else $error("period read wrong");

	AST_READ_CTRL: assert property ( // see [R16]
		(reg_rd && sel_ctrl)
		|=> reg_rdata == $past(ctrl_reg))
		else $error("control read wrong");

	AST_READ_FLAG: assert property ( // see [R11]
		(reg_rd && sel_flag)
		|=> reg_rdata[PMT_FLAG_BIT] == $past(match_flag_reg))
		else $error("flag read wrong");

	AST_RDATA_IDLE: assert property ( // see [R6]
		!reg_rd
		|=> reg_rdata == PMT_ZERO)
		else $error("read data without read");

	// ==========================================================
	// checks: counting and outputs
	AST_COUNT_HOLD: assert property ( // see [R2]
		(!pre_tick && !wr_count)
		|=> $stable(count_reg))
		else $error("count moved without tick");

	AST_MATCH_QUIET: assert property ( // see [R13]
		!(pre_tick && period_equal)
		|=> !match_pulse)
		else $error("match pulse without match");

	AST_SLEEP_NO_TICK: assert property ( // see [R15]
		sleep_req
		|-> !pre_tick)
		else $error("prescaler ticked in sleep");

	AST_SLEEP_NO_MATCH: assert property ( // see [R15]
		sleep_req
		|=> !match_pulse)
		else $error("match pulse in sleep");

	AST_RUN_NO_TICK: assert property ( // see [R17]
		!timer_run
		|-> !pre_tick)
		else $error("prescaler ticked while stopped");

	AST_CLEAR_NO_MATCH: assert property ( // see [R8]
		scaler_clear
		|-> !match_now)
		else $error("match on a scaler clear");

	AST_SHIFT_HOLD: assert property ( // see [R14]
		!match_now
		|=> $stable(spi_shift_clk))
		else $error("shift clock moved without match");

	// ==========================================================
	// checks: flag and interrupt
	AST_FLAG_CLEAR: assert property ( // see [R11]
		(rd_flag && !post_pulse)
		|=> !match_flag_reg)
		else $error("flag survived its read");

	AST_FLAG_RISE: assert property ( // see [R11]
		$rose(match_flag_reg)
		|-> $past(post_pulse))
		else $error("flag set without postscaler pulse");

	AST_IRQ_ON: assert property ( // see [R12]
		(match_flag_reg && match_irq_enable_reg)
		|-> irq)
		else $error("enabled interrupt missing");

	AST_IRQ_OFF: assert property ( // see [R12]
		!match_flag_reg
		|-> !irq)
		else $error("interrupt without flag");

	AST_POST_AT_MATCH: assert property ( // see [R10]
		post_pulse
		|-> match_now)
		else $error("postscaler pulse without match");

	COV_MATCH: cover property (match_now);
	COV_IRQ: cover property (irq ##1 rd_flag);
	COV_SET_CLEAR: cover property (post_pulse && rd_flag);
	COV_SLEEP: cover property (timer_run && sleep_req ##1 !sleep_req);
	COV_PRE64: cover property (pre_tick && prescale_select == PMT_PRE_64);
endmodule

/* tb/test_period_match_timer_8bit.sv */
`timescale 1ns/1ps
module test_period_match_timer_8bit;
	import pmt_pkg::*;
	// ==========================================
	// design connections
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [PMT_AW-1:0] reg_addr = '0;
	logic [PMT_DW-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [PMT_DW-1:0] reg_rdata;
	logic sleep_req = 1'b0;
	logic match_pulse;
	logic spi_shift_clk;
	logic irq;
	int err_count = 0;
	int tests_run = 0;
	logic [15:0] seed = 16'h7452;
	pmt_timer i_dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req),
		.match_pulse(match_pulse), .spi_shift_clk(spi_shift_clk), .irq(irq));
	always #50 clock = ~clock;
	// ==========================================
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic int pre_div(input logic [1:0] code);
		return 1 << (2 * code);
	endfunction
	task automatic end_of_test();
		$display("errors %0d checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask
	// strobes rise and fall by nba right after an edge
	task automatic wr(input logic [PMT_AW-1:0] a, input logic [PMT_DW-1:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [PMT_AW-1:0] a, output logic [PMT_DW-1:0] d);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic rdchk(input logic [PMT_AW-1:0] a, input logic [PMT_DW-1:0] exp);
		logic [PMT_DW-1:0] d;
		rd(a, d);
		chk({8'h00, d}, {8'h00, exp});
	endtask
	// cycles up to and including the next match pulse
	task automatic wait_pulse(output int n);
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (match_pulse !== 1'b1 && n < 5000);
		if (n >= 5000) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, 16'h0, 16'h1);
			err_count++;
		end
	endtask
	// ==========================================
	// watchdog: the whole sequence needs well under 20000 cycles
	initial begin
		#(100 * 60000);
		err_count++;
		end_of_test();
	end
	// ==========================================
	// main sequence
	initial begin
		int n, cnt;
		logic [7:0] p, a, b;
		logic [3:0] k;
		logic s0;
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		rdchk(PMT_ADDR_CTRL, 8'h00);
		rdchk(PMT_ADDR_COUNT, 8'h00);
		rdchk(PMT_ADDR_PERIOD, 8'hff);
		rdchk(PMT_ADDR_FLAG, 8'h00);
		rdchk(PMT_ADDR_IRQEN, 8'h00);
		wr(3'h5, 8'haa);
		rdchk(3'h5, 8'h00);
		wr(PMT_ADDR_CTRL, 8'hff);
		rdchk(PMT_ADDR_CTRL, 8'h7f);
		wr(PMT_ADDR_CTRL, 8'h00);
		// stopped: registers read back, equal count and period give no match
		seed = lfsr(seed);
		wr(PMT_ADDR_COUNT, seed[7:0]);
		wr(PMT_ADDR_PERIOD, seed[7:0]);
		rdchk(PMT_ADDR_COUNT, seed[7:0]);
		rdchk(PMT_ADDR_PERIOD, seed[7:0]);
		cnt = 0;
		repeat (30) begin
			@(posedge clock);
			#1;
			if (match_pulse === 1'b1) cnt++;
		end
		chk(16'(cnt), 16'h0);
		rdchk(PMT_ADDR_COUNT, seed[7:0]);
		// match spacing for every prescale code
		for (int c = 0; c < 4; c++) begin
			seed = lfsr(seed);
			p = 8'h02 + {5'h00, seed[2:0]};
			wr(PMT_ADDR_CTRL, 8'h00);
			wr(PMT_ADDR_PERIOD, p);
			wr(PMT_ADDR_COUNT, 8'h00);
			wr(PMT_ADDR_CTRL, {5'h01, c[1:0]});
			wait_pulse(n);
			// count the next gap from the pulse edge itself
			s0 = spi_shift_clk;
			wait_pulse(n);
			chk(16'(n), 16'(pre_div(c[1:0]) * (p + 1)));
			#150;
			chk({15'h0, spi_shift_clk}, {15'h0, ~s0});
		end
		// flag set with interrupt masked: no irq, read clears
		wr(PMT_ADDR_CTRL, 8'h00);
		#1;
		chk({15'h0, irq}, 16'h0);
		rdchk(PMT_ADDR_FLAG, 8'h01);
		rdchk(PMT_ADDR_FLAG, 8'h00);
		wr(PMT_ADDR_FLAG, 8'h01);
		rdchk(PMT_ADDR_FLAG, 8'h00);
		// postscaler: corner codes and one drawn at random
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			k = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'h1 + (seed[3:0] % 4'he);
			wr(PMT_ADDR_CTRL, 8'h00);
			rd(PMT_ADDR_FLAG, a);
			wr(PMT_ADDR_IRQEN, 8'h01);
			wr(PMT_ADDR_PERIOD, 8'h02 + {5'h00, seed[6:4]});
			wr(PMT_ADDR_COUNT, 8'h00);
			wr(PMT_ADDR_CTRL, {1'b0, k, 3'h4});
			cnt = 0;
			n = 0;
			while (irq !== 1'b1 && n < 3000) begin
				@(posedge clock);
				#1;
				n++;
				if (match_pulse === 1'b1) cnt++;
			end
			chk(16'(cnt), 16'(k) + 16'h1);
			wr(PMT_ADDR_CTRL, 8'h00);
			rdchk(PMT_ADDR_FLAG, 8'h01);
			@(posedge clock);
			#1;
			chk({15'h0, irq}, 16'h0);
		end
		// sleep freezes count and period
		wr(PMT_ADDR_PERIOD, 8'hff);
		wr(PMT_ADDR_COUNT, 8'h00);
		wr(PMT_ADDR_CTRL, 8'h04);
		@(posedge clock);
		sleep_req <= 1'b1;
		rd(PMT_ADDR_COUNT, a);
		repeat (30) @(posedge clock);
		rdchk(PMT_ADDR_COUNT, a);
		rdchk(PMT_ADDR_PERIOD, 8'hff);
		@(posedge clock);
		sleep_req <= 1'b0;
		repeat (10) @(posedge clock);
		rd(PMT_ADDR_COUNT, b);
		chk({15'h0, b > a}, 16'h1);
		// reset mid-run restores defaults
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		rdchk(PMT_ADDR_COUNT, 8'h00);
		rdchk(PMT_ADDR_PERIOD, 8'hff);
		rdchk(PMT_ADDR_CTRL, 8'h00);
		chk({14'h0, match_pulse, spi_shift_clk}, 16'h0);
		end_of_test();
	end
endmodule
